/* File: dbc_defines.svh */
// register offsets, field positions, reset values and sizes of the breakpoint control block
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

`define DBC_NUM_SLOTS 4
`define DBC_ADDR_W 8

`define DBC_OFF_ADDR(i) (8'h00 + 8'(4 * (i)))
`define DBC_OFF_STATUS 8'h18
`define DBC_OFF_CTL 8'h1C

`define DBC_CTL_LOCAL_EN(i) (2 * (i))
`define DBC_CTL_GLOBAL_EN(i) (2 * (i) + 1)
`define DBC_CTL_EXACT_LOCAL 8
`define DBC_CTL_EXACT_GLOBAL 9
`define DBC_CTL_GUARD 13
`define DBC_CTL_ACCESS(i) (16 + 4 * (i))
`define DBC_CTL_SPAN(i) (18 + 4 * (i))

`define DBC_STS_HIT(i) (i)
`define DBC_STS_GUARD 13

`define DBC_RST_ADDR 32'h0000_0000
`define DBC_RST_FIELD 2'h0

`define DBC_SPAN_BYTE 2'h0
`define DBC_SPAN_WORD 2'h1
`define DBC_SPAN_DWORD 2'h3
`define DBC_ACC_EXEC 2'h0
`define DBC_ACC_WRITE 2'h1
`define DBC_ACC_RDWR 2'h3

`endif

/* File: dbc_pkg.sv */
// types shared by the breakpoint control block
`default_nettype none
package dbc_pkg;
    typedef logic [1:0] dbc_field_t;
    typedef enum logic {
        TRAP_IDLE,
        TRAP_ARMED
    } dbc_trap_state_e;
endpackage
`default_nettype wire

/* File: dbc_slot_match.sv */
// one breakpoint slot: execution and data address comparators
`timescale 1ns/1ps
`default_nettype none
`include "dbc_defines.svh"
module dbc_slot_match (
    input wire logic [31:0] bp_addr,
    input wire dbc_pkg::dbc_field_t span,
    input wire dbc_pkg::dbc_field_t access,
    input wire logic [31:0] fetch_addr,
    input wire logic [31:0] data_addr,
    input wire logic [1:0] data_len_m1,
    input wire logic data_write,
    output logic exec_match,
    output logic data_match
);
    wire logic [31:0] ignore_mask;
    wire logic [3:0] byte_in_field;
    wire logic type_ok;

    // low address bits not used by the span
    assign ignore_mask = (span == `DBC_SPAN_WORD) ? 32'h0000_0001 :
                         (span == `DBC_SPAN_DWORD) ? 32'h0000_0003 : 32'h0000_0000;

    // each byte of the access checked against the aligned field
    genvar k;
    generate
        for (k = 0; k < 4; k++)
        begin : g_byte
            wire logic [31:0] byte_addr;
            assign byte_addr = data_addr + 32'(k);
            assign byte_in_field[k] = (2'(k) <= data_len_m1) &&
                                      ((byte_addr & ~ignore_mask) == (bp_addr & ~ignore_mask));
        end
    endgenerate

    // reserved encodings never match
    assign type_ok = (access == `DBC_ACC_RDWR) || ((access == `DBC_ACC_WRITE) && data_write);
    assign data_match = type_ok && (span != 2'h2) && (|byte_in_field);

    // only the first byte of an instruction, prefixes included, is presented
    assign exec_match = (access == `DBC_ACC_EXEC) && (span == `DBC_SPAN_BYTE) &&
                        (fetch_addr == bp_addr);
endmodule
`default_nettype wire

/* File: dbc_breakpoint_ctrl.sv */
// breakpoint control: slot registers, matching, faults, traps and task-switch clearing
//
// How it works
// - span field selects 1, 2 or 4 byte field
// - access field selects execute, write or read/write
// - data access overlapping field raises trap
// - execution breakpoint needs both fields 00, faults
// - execution match only on first instruction byte
// - register access only real mode or level 0
// - guard bit faults any debug register access
// - handler entry clears guard after guard fault
// - exact mode stalls until operand transfers finish
// - without exact mode data trap may lag
// - task switch clears local exact enable
// - global exact enable survives task switch
// - execution breakpoints always reported exactly
// - slot enabled by global or local enable
// - task switch clears all local slot enables
// - global slot enables survive task switch
// - all slots disabled after reset
// - slot address registers hold 32-bit linear addresses
// - any enabled hit sets all matching hit flags
// - guard fault sets guard violation flag
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dbc_defines.svh"
module dbc_breakpoint_ctrl #(
    parameter int ADDR_W = `DBC_ADDR_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic real_mode,
    input wire logic [1:0] cpl,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic data_valid,
    input wire logic [31:0] data_addr,
    input wire logic [1:0] data_len_m1,
    input wire logic data_write,
    input wire logic ops_pending,
    input wire logic insn_done,
    input wire logic task_switch,
    input wire logic exc_entry,
    output logic bp_fault,
    output logic bp_trap,
    output logic guard_fault,
    output logic priv_fault,
    output logic stall_next
);
    localparam int NS = `DBC_NUM_SLOTS;

    // control and address state
    logic [31:0] breakpoint_address_regs [NS];
    dbc_pkg::dbc_field_t bp_span_size [NS];
    dbc_pkg::dbc_field_t bp_access_type [NS];
    logic [NS-1:0] bp_enable_local;
    logic [NS-1:0] bp_enable_global;
    logic exact_match_local;
    logic exact_match_global;
    logic debug_reg_guard;
    logic [NS-1:0] bp_hit_flag;
    logic guard_violation_flag;
    logic guard_fault_taken;
    dbc_pkg::dbc_trap_state_e trap_state;
    dbc_pkg::dbc_trap_state_e next_trap_state;

    // access qualification
    wire logic acc_req;
    wire logic priv_ok;
    wire logic guard_block;
    wire logic priv_block;
    wire logic wr_ok;
    wire logic rd_ok;
    wire logic sel_status;
    wire logic sel_ctl;
    wire logic [NS-1:0] sel_addr;
    wire logic wr_ctl;
    wire logic wr_status;

    assign acc_req = reg_wr | reg_rd;
    assign priv_ok = real_mode | (cpl == 2'h0);
    assign guard_block = acc_req & debug_reg_guard;
    assign priv_block = acc_req & ~debug_reg_guard & ~priv_ok;
    assign wr_ok = reg_wr & ~debug_reg_guard & priv_ok;
    assign rd_ok = reg_rd & ~debug_reg_guard & priv_ok;
    assign sel_status = (reg_addr == ADDR_W'(`DBC_OFF_STATUS));
    assign sel_ctl = (reg_addr == ADDR_W'(`DBC_OFF_CTL));
    assign wr_ctl = wr_ok & sel_ctl;
    assign wr_status = wr_ok & sel_status;

    // slot comparators and readback
    wire logic [NS-1:0] exec_hit_vec;
    wire logic [NS-1:0] data_hit_vec;
    wire logic [NS-1:0] slot_en;
    wire logic [31:0] ctl_word;
    wire logic [31:0] status_word;
    wire logic [31:0] addr_rd [NS];
    wire logic [31:0] slot_word [NS];
    wire logic [31:0] addr_or [NS+1];
    wire logic [31:0] ctl_or [NS+1];

    assign slot_en = bp_enable_local | bp_enable_global;

    // readback words folded slot by slot
    assign addr_or[0] = 32'h0000_0000;
    assign ctl_or[0] = 32'h0000_0000;

    genvar i;
    generate
        for (i = 0; i < NS; i++)
        begin : g_slot
            assign sel_addr[i] = (reg_addr == ADDR_W'(`DBC_OFF_ADDR(i)));
            assign addr_rd[i] = sel_addr[i] ? breakpoint_address_regs[i] : 32'h0000_0000;
            assign slot_word[i] = (32'(bp_enable_local[i]) << `DBC_CTL_LOCAL_EN(i)) |
                                  (32'(bp_enable_global[i]) << `DBC_CTL_GLOBAL_EN(i)) |
                                  (32'(bp_access_type[i]) << `DBC_CTL_ACCESS(i)) |
                                  (32'(bp_span_size[i]) << `DBC_CTL_SPAN(i));
            assign addr_or[i+1] = addr_or[i] | addr_rd[i];
            assign ctl_or[i+1] = ctl_or[i] | slot_word[i];

            dbc_slot_match u_match (
                .bp_addr(breakpoint_address_regs[i]),
                .span(bp_span_size[i]),
                .access(bp_access_type[i]),
                .fetch_addr(fetch_addr),
                .data_addr(data_addr),
                .data_len_m1(data_len_m1),
                .data_write(data_write),
                .exec_match(exec_hit_vec[i]),
                .data_match(data_hit_vec[i])
            );

            // address register, compared continuously as a linear address
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    breakpoint_address_regs[i] <= `DBC_RST_ADDR;
                else if (wr_ok && sel_addr[i])
                    breakpoint_address_regs[i] <= reg_wdata;
            end

            // slot fields and enables; task switch drops local enable only
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    bp_span_size[i] <= `DBC_RST_FIELD;
                    bp_access_type[i] <= `DBC_RST_FIELD;
                    bp_enable_local[i] <= 1'b0;
                    bp_enable_global[i] <= 1'b0;
                end
                else
                begin
                    if (wr_ctl)
                    begin
                        bp_span_size[i] <= reg_wdata[`DBC_CTL_SPAN(i) +: 2];
                        bp_access_type[i] <= reg_wdata[`DBC_CTL_ACCESS(i) +: 2];
                        bp_enable_global[i] <= reg_wdata[`DBC_CTL_GLOBAL_EN(i)];
                    end
                    if (task_switch)
                        bp_enable_local[i] <= 1'b0;
                    else if (wr_ctl)
                        bp_enable_local[i] <= reg_wdata[`DBC_CTL_LOCAL_EN(i)];
                end
            end
        end
    endgenerate

    assign ctl_word = ctl_or[NS] |
                      (32'(exact_match_local) << `DBC_CTL_EXACT_LOCAL) |
                      (32'(exact_match_global) << `DBC_CTL_EXACT_GLOBAL) |
                      (32'(debug_reg_guard) << `DBC_CTL_GUARD);
    assign status_word = 32'(bp_hit_flag) | (32'(guard_violation_flag) << `DBC_STS_GUARD);

    // read data, zero for unmapped or refused reads
    wire logic [31:0] rd_mux;
    wire logic [31:0] next_rdata;

    assign rd_mux = addr_or[NS] |
                    (sel_ctl ? ctl_word : 32'h0000_0000) |
                    (sel_status ? status_word : 32'h0000_0000);
    assign next_rdata = rd_ok ? rd_mux : 32'h0000_0000;

    // breakpoint detection on enabled slots
    wire logic any_exec;
    wire logic any_data;
    wire logic [NS-1:0] hit_set;
    wire logic exact_on;

    assign any_exec = fetch_valid & (|(exec_hit_vec & slot_en));
    assign any_data = data_valid & (|(data_hit_vec & slot_en));
    // disabled slots that match at the same instant are flagged too
    assign hit_set = (any_exec ? exec_hit_vec : {NS{1'b0}}) |
                     (any_data ? data_hit_vec : {NS{1'b0}});
    assign exact_on = exact_match_local | exact_match_global;

    // status flags: hardware set wins over a software write
    wire logic [NS-1:0] next_hit_flag;
    wire logic next_guard_flag;

    assign next_hit_flag = (wr_status ? reg_wdata[NS-1:0] : bp_hit_flag) | hit_set;
    assign next_guard_flag = (wr_status ? reg_wdata[`DBC_STS_GUARD] : guard_violation_flag) |
                             guard_block;

    // guard bit: written by software, dropped on handler entry after a guard fault
    wire logic next_guard;
    wire logic next_guard_taken;

    assign next_guard = (exc_entry && guard_fault_taken) ? 1'b0 :
                        wr_ctl ? reg_wdata[`DBC_CTL_GUARD] : debug_reg_guard;
    assign next_guard_taken = guard_block | (guard_fault_taken & ~exc_entry);

    // data trap waits for the end of the causing instruction
    always_comb
    begin
        next_trap_state = trap_state;
        case (trap_state)
            dbc_pkg::TRAP_IDLE:
                if (any_data)
                    next_trap_state = dbc_pkg::TRAP_ARMED;
            dbc_pkg::TRAP_ARMED:
                if (insn_done && !any_data)
                    next_trap_state = dbc_pkg::TRAP_IDLE;
            default:
                next_trap_state = dbc_pkg::TRAP_IDLE;
        endcase
    end

    wire logic next_trap;
    // without exact mode no stall, so the end may come after later instructions
    assign next_trap = (trap_state == dbc_pkg::TRAP_ARMED) & insn_done;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            exact_match_local <= 1'b0;
        else if (task_switch)
            exact_match_local <= 1'b0;
        else if (wr_ctl)
            exact_match_local <= reg_wdata[`DBC_CTL_EXACT_LOCAL];
    end

    // global exact enable ignores task switches
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            exact_match_global <= 1'b0;
        else if (wr_ctl)
            exact_match_global <= reg_wdata[`DBC_CTL_EXACT_GLOBAL];
    end

    // guard bit and the record of a pending guard fault
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            debug_reg_guard <= 1'b0;
            guard_fault_taken <= 1'b0;
        end
        else
        begin
            debug_reg_guard <= next_guard;
            guard_fault_taken <= next_guard_taken;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bp_hit_flag <= {NS{1'b0}};
            guard_violation_flag <= 1'b0;
        end
        else
        begin
            bp_hit_flag <= next_hit_flag;
            guard_violation_flag <= next_guard_flag;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            trap_state <= dbc_pkg::TRAP_IDLE;
        else
            trap_state <= next_trap_state;
    end

    // output pulses, one cycle after their cause
    wire logic next_fault;
    wire logic next_guard_fault;
    wire logic next_priv_fault;
    wire logic next_stall;

    assign next_fault = any_exec;
    assign next_guard_fault = guard_block;
    assign next_priv_fault = priv_block;
    assign next_stall = exact_on & ops_pending;

    // registered outputs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= next_rdata;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bp_fault <= 1'b0;
            bp_trap <= 1'b0;
        end
        else
        begin
            bp_fault <= next_fault;
            bp_trap <= next_trap;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            guard_fault <= 1'b0;
            priv_fault <= 1'b0;
            stall_next <= 1'b0;
        end
        else
        begin
            guard_fault <= next_guard_fault;
            priv_fault <= next_priv_fault;
            stall_next <= next_stall;
        end
    end
endmodule
`default_nettype wire

/* File: dbc_breakpoint_ctrl_chk.sv */
// port checker for the breakpoint control block
`timescale 1ns/1ps
`default_nettype none
module dbc_breakpoint_ctrl_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic real_mode,
    input wire logic [1:0] cpl,
    input wire logic fetch_valid,
    input wire logic ops_pending,
    input wire logic insn_done,
    input wire logic bp_fault,
    input wire logic bp_trap,
    input wire logic guard_fault,
    input wire logic priv_fault,
    input wire logic stall_next
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_bad_priv;
        (reg_wr || reg_rd) && !real_mode && cpl != 2'h0;
    endsequence
    sequence s_good_priv;
        (reg_wr || reg_rd) && (real_mode || cpl == 2'h0);
    endsequence
    property p_rst_quiet;
        !$past(rst_n) |-> !(bp_fault || bp_trap || guard_fault || priv_fault || stall_next);
    endproperty
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    property p_priv_refuse;
        s_bad_priv |=> priv_fault || guard_fault;
    endproperty
    property p_priv_allow;
        s_good_priv |=> !priv_fault;
    endproperty
    property p_guard_cause;
        guard_fault |-> $past(reg_wr || reg_rd);
    endproperty
    property p_one_fault;
        !(guard_fault && priv_fault);
    endproperty
    property p_fault_cause;
        bp_fault |-> $past(fetch_valid);
    endproperty
    property p_trap_cause;
        bp_trap |-> $past(insn_done);
    endproperty
    property p_stall;
        !ops_pending |=> !stall_next;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    a_priv_refuse: assert property (p_priv_refuse) else $error("unprivileged access taken");
    a_priv_allow: assert property (p_priv_allow) else $error("privileged access refused");
    a_guard_cause: assert property (p_guard_cause) else $error("guard fault without access");
    a_one_fault: assert property (p_one_fault) else $error("two access faults at once");
    a_fault_cause: assert property (p_fault_cause) else $error("fault without fetch");
    a_trap_cause: assert property (p_trap_cause) else $error("trap without completion");
    a_stall: assert property (p_stall) else $error("stall without pending transfers");
endmodule
`default_nettype wire

/* File: dbc_core_model.sv */
// model of the core's fetch and operand side
`timescale 1ns/1ps
`default_nettype none
module dbc_core_model (
    input wire logic core_clk,
    input wire logic do_fetch,
    input wire logic do_data,
    input wire logic do_done,
    input wire logic [31:0] req_addr,
    input wire logic [1:0] req_len_m1,
    input wire logic req_write,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic data_valid,
    output logic [31:0] data_addr,
    output logic [1:0] data_len_m1,
    output logic data_write,
    output logic insn_done
);
    initial
    begin
        {fetch_valid, data_valid, insn_done, data_write} = 4'h0;
        {fetch_addr, data_addr, data_len_m1} = 66'h0;
    end
    // idle buses show inverted values, not stale ones
    always @(posedge core_clk)
    begin
        fetch_valid <= do_fetch;
        data_valid <= do_data;
        insn_done <= do_done;
        fetch_addr <= do_fetch ? req_addr : ~fetch_addr;
        data_addr <= do_data ? req_addr : ~data_addr;
        data_len_m1 <= do_data ? req_len_m1 : ~data_len_m1;
        data_write <= do_data ? req_write : ~data_write;
    end
endmodule
`default_nettype wire

/* File: test_debug_breakpoint_control.sv */
// self-checking bench for the breakpoint control block
`timescale 1ns/1ps
`default_nettype none
`include "dbc_defines.svh"
module test_debug_breakpoint_control;
    logic core_clk, rst_n, reg_wr, reg_rd, real_mode, ops_pending, task_switch, exc_entry;
    logic fetch_valid, data_valid, data_write, insn_done, bp_fault, bp_trap, guard_fault, priv_fault, stall_next;
    logic do_fetch, do_data, do_done, req_write;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fetch_addr, data_addr, req_addr;
    logic [1:0] cpl, data_len_m1, req_len_m1;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    dbc_breakpoint_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .real_mode(real_mode), .cpl(cpl),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .data_valid(data_valid), .data_addr(data_addr),
        .data_len_m1(data_len_m1), .data_write(data_write), .ops_pending(ops_pending), .insn_done(insn_done),
        .task_switch(task_switch), .exc_entry(exc_entry), .bp_fault(bp_fault), .bp_trap(bp_trap),
        .guard_fault(guard_fault), .priv_fault(priv_fault), .stall_next(stall_next));
    dbc_core_model core_m (.core_clk(core_clk), .do_fetch(do_fetch), .do_data(do_data), .do_done(do_done),
        .req_addr(req_addr), .req_len_m1(req_len_m1), .req_write(req_write), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .data_valid(data_valid), .data_addr(data_addr), .data_len_m1(data_len_m1),
        .data_write(data_write), .insn_done(insn_done));
    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkf(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask
    // kind bits: done, data, fetch; result visible on return
    task automatic core(input logic [2:0] k, input logic [31:0] a, input logic [1:0] l, input logic w);
        @(posedge core_clk);
        {do_done, do_data, do_fetch} <= k;
        req_addr <= a;
        req_len_m1 <= l;
        req_write <= w;
        @(posedge core_clk);
        {do_done, do_data, do_fetch} <= 3'h0;
        @(posedge core_clk);
        #1;
    endtask
    function automatic logic dhit(input logic [31:0] b, input logic [1:0] s, input logic [1:0] t,
        input logic [31:0] a, input logic [1:0] l, input logic w);
        logic [31:0] m;
        logic h;
        m = (s == 2'h0) ? 32'hFFFFFFFF : (s == 2'h1) ? 32'hFFFFFFFE : 32'hFFFFFFFC;
        h = 1'b0;
        for (int k = 0; k <= int'(l); k++)
            h = h | (((a + 32'(k)) & m) == (b & m));
        return h & (t == 2'h3 || (t == 2'h1 && w));
    endfunction
    function automatic logic [31:0] ctl(input int i, input logic [1:0] en, input logic [1:0] t, input logic [1:0] s);
        return (32'(en) << (2 * i)) | (32'(t) << (16 + 4 * i)) | (32'(s) << (18 + 4 * i));
    endfunction
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        logic [31:0] a, b;
        logic [1:0] s, t, l;
        {rst_n, reg_wr, reg_rd, ops_pending, task_switch, exc_entry, do_fetch, do_data, do_done} = 9'h0;
        {reg_addr, reg_wdata, req_addr, req_len_m1, req_write} = 75'h0;
        real_mode = 1'b1;
        cpl = 2'h3;
        void'($urandom(32'h2610));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
            rchk(`DBC_OFF_ADDR(i), 32'h0);
        rchk(`DBC_OFF_CTL, 32'h0);
        rchk(8'h10, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            a = $urandom;
            wr(`DBC_OFF_ADDR(i), a);
            wr(`DBC_OFF_CTL, ctl(i, 2'(i % 3 + 1), 2'h0, 2'h0));
            wr(`DBC_OFF_STATUS, 32'h0);
            core(3'h1, a + 32'h1, 2'h0, 1'b0);
            chkf("fault", 1'b0, bp_fault);
            core(3'h1, a, 2'h0, 1'b0);
            chkf("fault", 1'b1, bp_fault);
            rchk(`DBC_OFF_STATUS, 32'h1 << i);
        end
        a = $urandom;
        for (int i = 0; i < 3; i++)
            wr(`DBC_OFF_ADDR(i), a);
        wr(`DBC_OFF_STATUS, 32'h0);
        core(3'h1, a, 2'h0, 1'b0);
        chkf("fault", 1'b0, bp_fault);
        rchk(`DBC_OFF_STATUS, 32'h0);
        wr(`DBC_OFF_CTL, 32'h0000_000A);
        core(3'h1, a, 2'h0, 1'b0);
        chkf("fault", 1'b1, bp_fault);
        @(posedge core_clk);
        #1 chkf("fault", 1'b0, bp_fault);
        rchk(`DBC_OFF_STATUS, 32'h7);
        // reserved encoding 10 is never programmed
        for (int n = 0; n < 24; n++)
        begin
            s = (n % 3 == 2) ? 2'h3 : 2'(n % 3);
            t = (n % 2 == 1) ? 2'h3 : 2'h1;
            b = $urandom;
            a = b + 32'($urandom_range(8)) - 32'h4;
            l = 2'($urandom);
            wr(`DBC_OFF_ADDR(0), b);
            wr(`DBC_OFF_CTL, ctl(0, 2'h2, t, s) | 32'h200);
            core(3'h2, a, l, n[2]);
            core(3'h4, 32'h0, 2'h0, 1'b0);
            chkf("trap", dhit(b, s, t, a, l, n[2]), bp_trap);
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(`DBC_OFF_CTL, (i == 0) ? 32'h3FF : (i == 1) ? 32'h100 : 32'h0);
            @(posedge core_clk);
            ops_pending <= 1'b1;
            @(posedge core_clk);
            ops_pending <= 1'b0;
            #1 chkf("stall", i != 2, stall_next);
        end
        wr(`DBC_OFF_CTL, 32'h3FF);
        @(posedge core_clk);
        task_switch <= 1'b1;
        @(posedge core_clk);
        task_switch <= 1'b0;
        rchk(`DBC_OFF_CTL, 32'h2AA);
        @(posedge core_clk);
        real_mode <= 1'b0;
        wr(`DBC_OFF_CTL, 32'h3);
        chkf("priv", 1'b1, priv_fault);
        @(posedge core_clk);
        cpl <= 2'h0;
        rchk(`DBC_OFF_CTL, 32'h2AA);
        chkf("priv", 1'b0, priv_fault);
        wr(`DBC_OFF_STATUS, 32'h0);
        wr(`DBC_OFF_CTL, 32'h2000);
        rchk(`DBC_OFF_CTL, 32'h0);
        chkf("guard", 1'b1, guard_fault);
        @(posedge core_clk);
        exc_entry <= 1'b1;
        @(posedge core_clk);
        exc_entry <= 1'b0;
        rchk(`DBC_OFF_CTL, 32'h0);
        chkf("guard", 1'b0, guard_fault);
        rchk(`DBC_OFF_STATUS, 32'h2000);
        end_sim();
    end
endmodule
bind dbc_breakpoint_ctrl dbc_breakpoint_ctrl_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .real_mode(real_mode), .cpl(cpl), .fetch_valid(fetch_valid),
    .ops_pending(ops_pending), .insn_done(insn_done), .bp_fault(bp_fault), .bp_trap(bp_trap),
    .guard_fault(guard_fault), .priv_fault(priv_fault), .stall_next(stall_next));
`default_nettype wire
